// [src/frc_regs.vh]
`ifndef FRC_REGS_VH
`define FRC_REGS_VH

// register indices on the word-wide port, not byte addresses
`define FRC_ADDR_W 12
`define FRC_CTRL_ADDR 12'hF2C
`define FRC_IRQ_STAT_ADDR 12'hF30
`define FRC_IRQ_MASK_ADDR 12'hF31

// control register fields
`define FRC_BIT_REF_EN 7
`define FRC_BIT_REF_RDY 6
`define FRC_BIT_TS_EN 5
`define FRC_BIT_TS_RNG 4
`define FRC_CMP_GAIN_HI 3
`define FRC_CMP_GAIN_LO 2
`define FRC_ADC_GAIN_HI 1
`define FRC_ADC_GAIN_LO 0

// reset values
`define FRC_CTRL_RESET 8'h00
`define FRC_MASK_RESET 8'h00

// gain codes
`define FRC_GAIN_OFF 2'h0
`define FRC_GAIN_1X 2'h1
`define FRC_GAIN_2X 2'h2
`define FRC_GAIN_4X 2'h3

// interrupt status bits
`define FRC_IRQ_READY 0
`define FRC_IRQ_LOST 1

// stabilisation time and clock period in ns
`define FRC_SETTLE_NS 25000
`define FRC_CLK_NS 8

`endif

// [src/frc_gain_dec.v]
`timescale 1ns/10ps
// decodes one two-bit gain select into buffer enable and one-hot gain
module frc_gain_dec (
  // select in
  input wire [1:0] gain_sel,
  // decoded out
  output reg buf_on,
  output reg [2:0] gain_onehot
);
`include "frc_regs.vh"

  // code 00 turns the buffer off and drives no gain
  always @* begin
    buf_on = 1'b1;
    gain_onehot = 3'h0;
    case (gain_sel)
      `FRC_GAIN_OFF: begin
        buf_on = 1'b0;
      end
      `FRC_GAIN_1X: begin
        gain_onehot = 3'h1;
      end
      `FRC_GAIN_2X: begin
        gain_onehot = 3'h2;
      end
      default: begin
        gain_onehot = 3'h4;
      end
    endcase
  end

endmodule

// [src/frc_ctrl.v]
`timescale 1ns/10ps
`include "frc_regs.vh"
module frc_ctrl #(
  parameter SETTLE_CYCLES = (`FRC_SETTLE_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // reference controls to analog
  output wire reference_enable,
  output wire reference_ready,
  output wire adc_buf_on,
  output wire [2:0] adc_gain,
  output wire cmp_dac_buf_on,
  output wire [2:0] cmp_dac_gain,
  // temperature indicator controls
  output wire temp_sense_enable,
  output wire temp_range_select,
  // interrupt
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////
  // sizes and constants

  // counter width; settle counts above 65536 cycles need a wider one
  // sixteen bits hold the default settle count with room to spare
  localparam CNT_W = 16;
  // last count, cut to the counter width on purpose
  localparam [31:0] SETTLE_LAST = SETTLE_CYCLES - 1;
  localparam [CNT_W-1:0] SETTLE_MAX = SETTLE_LAST[CNT_W-1:0];
  // counter constants at full width, so nothing is padded silently
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  // reset images of the software registers
  localparam [7:0] CTRL_RST = `FRC_CTRL_RESET;
  localparam [7:0] MASK_RST = `FRC_MASK_RESET;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // control fields, flop and next value
  reg ref_en_q;
  reg ref_en_d;
  reg ts_en_q;
  reg ts_en_d;
  reg ts_rng_q;
  reg ts_rng_d;
  reg [1:0] cmp_gain_q;
  reg [1:0] cmp_gain_d;
  reg [1:0] adc_gain_q;
  reg [1:0] adc_gain_d;
  // settle tracking
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg rdy_q;
  reg rdy_d;
  // interrupt status and mask
  reg [1:0] stat_q;
  reg [1:0] stat_d;
  reg [1:0] mask_q;
  reg [1:0] mask_d;
  // address decode
  reg ctrl_sel;
  reg stat_sel;
  reg mask_sel;
  // read path
  reg [7:0] rd_image;
  reg [7:0] rdata_d;
  // strobes qualified by address
  wire ctrl_wr;
  wire mask_wr;
  wire stat_rd;
  // write data split into fields
  wire wr_ref_en;
  wire wr_ts_en;
  wire wr_ts_rng;
  wire [1:0] wr_cmp_gain;
  wire [1:0] wr_adc_gain;
  // settle and event strobes
  wire settle_done;
  wire ev_ready;
  wire ev_lost;
  wire [1:0] ev_vec;
  // control register as software reads it
  wire [7:0] ctrl_image;

  ////////////////////////////////////////////////////////////////////////
  // address decode and strobes

  // one register per index; unmapped indices select nothing
  // the three indices differ, so at most one select is high
  always @* begin
    ctrl_sel = 1'b0;
    stat_sel = 1'b0;
    mask_sel = 1'b0;
    if (reg_addr == `FRC_CTRL_ADDR) begin
      ctrl_sel = 1'b1;
    end else if (reg_addr == `FRC_IRQ_STAT_ADDR) begin
      stat_sel = 1'b1;
    end else if (reg_addr == `FRC_IRQ_MASK_ADDR) begin
      mask_sel = 1'b1;
    end
  end

  // writes to the status register are ignored
  assign ctrl_wr = reg_wr && ctrl_sel;
  assign mask_wr = reg_wr && mask_sel;
  assign stat_rd = reg_rd && stat_sel;

  // field slices of the write data; the ready position is dropped
  assign wr_ref_en = reg_wdata[`FRC_BIT_REF_EN];
  assign wr_ts_en = reg_wdata[`FRC_BIT_TS_EN];
  assign wr_ts_rng = reg_wdata[`FRC_BIT_TS_RNG];
  assign wr_cmp_gain = reg_wdata[`FRC_CMP_GAIN_HI:`FRC_CMP_GAIN_LO];
  assign wr_adc_gain = reg_wdata[`FRC_ADC_GAIN_HI:`FRC_ADC_GAIN_LO];

  ////////////////////////////////////////////////////////////////////////
  // control fields

  always @* begin
    ref_en_d = ref_en_q;
    if (ctrl_wr) begin
      ref_en_d = wr_ref_en;
    end
  end

  always @* begin
    ts_en_d = ts_en_q;
    if (ctrl_wr) begin
      ts_en_d = wr_ts_en;
    end
  end

  always @* begin
    ts_rng_d = ts_rng_q;
    if (ctrl_wr) begin
      ts_rng_d = wr_ts_rng;
    end
  end

  always @* begin
    cmp_gain_d = cmp_gain_q;
    if (ctrl_wr) begin
      cmp_gain_d = wr_cmp_gain;
    end
  end

  always @* begin
    adc_gain_d = adc_gain_q;
    if (ctrl_wr) begin
      adc_gain_d = wr_adc_gain;
    end
  end

  // control flops; the ready position has no flop here, it belongs
  // to the settle logic below
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_en_q <= CTRL_RST[`FRC_BIT_REF_EN];
      ts_en_q <= CTRL_RST[`FRC_BIT_TS_EN];
      ts_rng_q <= CTRL_RST[`FRC_BIT_TS_RNG];
      cmp_gain_q <= CTRL_RST[`FRC_CMP_GAIN_HI:`FRC_CMP_GAIN_LO];
      adc_gain_q <= CTRL_RST[`FRC_ADC_GAIN_HI:`FRC_ADC_GAIN_LO];
    end else begin
      ref_en_q <= ref_en_d;
      ts_en_q <= ts_en_d;
      ts_rng_q <= ts_rng_d;
      cmp_gain_q <= cmp_gain_d;
      adc_gain_q <= adc_gain_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stabilisation counter and ready flag

  // saturating at the last count keeps the ready flag from toggling
  assign settle_done = (cnt_q == SETTLE_MAX);

  always @* begin
    cnt_d = cnt_q;
    if (!ref_en_q) begin
      cnt_d = CNT_ZERO;
    end else if (!settle_done) begin
      cnt_d = cnt_q + CNT_ONE;
    end
  end

  // ready follows the counter one cycle late
  // a disable drops ready at the next edge, whatever the count
  always @* begin
    rdy_d = rdy_q;
    if (!ref_en_q) begin
      rdy_d = 1'b0;
    end else if (settle_done) begin
      rdy_d = 1'b1;
    end
  end

  // counter and ready flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_ZERO;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt events, status and mask

  // ready rising, and ready dropped by a disable
  // each event lasts one cycle, as it removes its own condition
  assign ev_ready = settle_done && ref_en_q && !rdy_q;
  assign ev_lost = rdy_q && !ref_en_q;
  assign ev_vec[`FRC_IRQ_READY] = ev_ready;
  assign ev_vec[`FRC_IRQ_LOST] = ev_lost;

  // a read clears, but an event in the same cycle wins so none is lost
  // the status register itself takes no writes
  always @* begin
    stat_d = stat_q;
    if (stat_rd) begin
      stat_d = 2'h0;
    end
    stat_d = stat_d | ev_vec;
  end

  // mask, one enables the interrupt for that status bit
  always @* begin
    mask_d = mask_q;
    if (mask_wr) begin
      mask_d = reg_wdata[1:0];
    end
  end

  // status and mask flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 2'h0;
      mask_q <= MASK_RST[1:0];
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // level output, high while any unmasked status bit is set
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // read path

  assign ctrl_image = {ref_en_q, rdy_q, ts_en_q, ts_rng_q, cmp_gain_q,
    adc_gain_q};

  // read mux; unmapped indices read zero
  always @* begin
    rd_image = 8'h00;
    if (ctrl_sel) begin
      rd_image = ctrl_image;
    end else if (stat_sel) begin
      rd_image = {6'h00, stat_q};
    end else if (mask_sel) begin
      rd_image = {6'h00, mask_q};
    end
  end

  // data stand only in the cycle after the strobe, zero otherwise
  // a read strobe with no matching index still returns zero
  always @* begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      rdata_d = rd_image;
    end
  end

  // status is captured before the same-edge clear lands
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain decoders

  // code 00 switches a buffer off; other codes give a one-hot gain
  // two separate decoders
  frc_gain_dec u_adc_dec (
    .gain_sel(adc_gain_q),
    .buf_on(adc_buf_on),
    .gain_onehot(adc_gain)
  );

  frc_gain_dec u_cmp_dec (
    .gain_sel(cmp_gain_q),
    .buf_on(cmp_dac_buf_on),
    .gain_onehot(cmp_dac_gain)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // level outputs straight from the control and ready flops
  // the analog side sees these with no extra delay
  assign reference_enable = ref_en_q;
  assign reference_ready = rdy_q;
  assign temp_sense_enable = ts_en_q;
  assign temp_range_select = ts_rng_q;

endmodule

// [test/frc_ctrl_sva.sv]
`timescale 1ns/10ps
module frc_ctrl_chk #(parameter SETTLE_CYCLES = 8) (
  // clock, reset and register port
  input wire clk_sys,
  input wire rst_n,
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // block outputs
  input wire reference_enable,
  input wire reference_ready,
  input wire adc_buf_on,
  input wire [2:0] adc_gain,
  input wire cmp_dac_buf_on,
  input wire [2:0] cmp_dac_gain,
  input wire temp_sense_enable,
  input wire temp_range_select,
  input wire irq
);
  wire wr_ctl = reg_wr && reg_addr == 12'hF2C;
  reg [7:0] wd_q;
  // write data kept for the cycle it takes effect
  always @(posedge clk_sys) begin
    wd_q <= reg_wdata;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // buffer on plus one-hot gain, off for code zero
  function automatic [3:0] dec(input [1:0] c);
    dec = c == 2'h0 ? 4'h0 : {1'b1, 3'h1 << (c - 2'h1)};
  endfunction
  en_set_a: assert property (wr_ctl |=> reference_enable == wd_q[7])
    else $error("enable wrong");
  ts_en_a: assert property (wr_ctl |=> temp_sense_enable == wd_q[5])
    else $error("sense enable wrong");
  ts_rng_a: assert property (wr_ctl |=> temp_range_select == wd_q[4])
    else $error("range wrong");
  adc_gain_a: assert property (wr_ctl |=>
    {adc_buf_on, adc_gain} == dec(wd_q[1:0])) else $error("adc gain");
  cmp_gain_a: assert property (wr_ctl |=>
    {cmp_dac_buf_on, cmp_dac_gain} == dec(wd_q[3:2])) else $error("cmp gain");
  rdy_off_a: assert property (!reference_enable |=> !reference_ready)
    else $error("ready while off");
  rdy_early_a: assert property ($rose(reference_enable) |->
    !reference_ready [*6]) else $error("ready early");
  // margin of a few cycles over the eight-cycle settle count
  rdy_late_a: assert property (reference_enable [*8] ##1
    reference_enable [*4] |-> reference_ready) else $error("ready late");
  cover property ($rose(reference_ready));
  cover property ($rose(irq));
  cover property (wr_ctl ##1 reg_rd);
endmodule
////////////////////////////////////////
bind frc_ctrl frc_ctrl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);

// [test/tb.sv]
`timescale 1ns/10ps
`include "frc_regs.vh"
module tb;
  reg clk_sys, rst_n, reg_wr, reg_rd, rd_seen;
  reg [11:0] reg_addr;
  reg [7:0] reg_wdata, ctl, v;
  wire [7:0] reg_rdata;
  wire reference_enable, reference_ready, adc_buf_on, cmp_dac_buf_on;
  wire temp_sense_enable, temp_range_select, irq;
  wire [2:0] adc_gain, cmp_dac_gain;
  reg [15:0] q[$];
  int err_total, num_checks, i;
  localparam [11:0] ca = `FRC_CTRL_ADDR, sa = `FRC_IRQ_STAT_ADDR;
  frc_ctrl #(.SETTLE_CYCLES(8)) u_frc_ctrl (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reference_enable(reference_enable), .reference_ready(reference_ready),
    .adc_buf_on(adc_buf_on), .adc_gain(adc_gain),
    .cmp_dac_buf_on(cmp_dac_buf_on), .cmp_dac_gain(cmp_dac_gain),
    .temp_sense_enable(temp_sense_enable),
    .temp_range_select(temp_range_select), .irq(irq));
  function [3:0] dec(input [1:0] c);
    dec = c == 2'h0 ? 4'h0 : {1'b1, 3'h1 << (c - 2'h1)};
  endfunction
  task chk(input [15:0] s, input [15:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: %h not %h", $time, s, e);
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  // note read data and the gains held at read time
  task rd(input [11:0] a, input [7:0] e);
    q.push_back({e, dec(ctl[1:0]), dec(ctl[3:2])});
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
  endtask
  task idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read data stands one cycle only, so look mid-cycle
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys) if (rd_seen === 1'b1)
    chk({reg_rdata, adc_buf_on, adc_gain, cmp_dac_buf_on, cmp_dac_gain},
      q.pop_front());
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // run is under a hundred cycles, well inside the 2500-cycle limit
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
  initial begin
    {rst_n, reg_wr, reg_rd} = 3'h0;
    {reg_addr, reg_wdata, ctl} = 28'h0;
    v = $urandom(32'h195C);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(12'h000, 8'hFF);
    rd(12'h000, 8'h00);
    rd(ca, 8'h00);
    rd(sa, 8'h00);
    idle(1);
    $display("reset test done");
    // every gain code on both paths, ready bit not writable
    for (i = 0; i < 16; i++) begin
      v = {2'h0, 2'($urandom), i[3:0]};
      ctl = v;
      wr(ca, v | 8'h40);
      rd(ca, v);
    end
    idle(1);
    $display("field test done");
    wr(`FRC_IRQ_MASK_ADDR, 8'h03);
    ctl = 8'h87;
    wr(ca, ctl);
    rd(ca, 8'h87);
    idle(12);
    chk(irq, 1'b1);
    rd(ca, 8'hC7);
    rd(sa, 8'h01);
    rd(sa, 8'h00);
    idle(2);
    chk(irq, 1'b0);
    ctl = 8'h00;
    wr(ca, ctl);
    idle(3);
    rd(ca, 8'h00);
    rd(sa, 8'h02);
    wr(`FRC_IRQ_MASK_ADDR, 8'h00);
    ctl = 8'h80;
    wr(ca, ctl);
    idle(12);
    chk(irq, 1'b0);
    $display("ready test done");
    finish_test;
  end
endmodule
